// File: sbf_buffer_ctl.sv
`timescale 1ns/1ps
`include "sbf_cfg.svh"
// Notes on behaviour
// - writing one to the flush bit discards all samples and clears buffer flags
// - flush also clears gate error flag and five-bit gate sample count
// - flush bit clears itself at once; a read always returns it as zero
// - with keep-awake enable at zero, auto-sleep ignores watermark and overflow flags
// - with keep-awake enable set, timer expiry with flags still set enters sleep
// - with keep-awake enable set, host clearing flags by flush or read restarts auto-sleep timer and stays awake
// - keep-awake enable acts only in stream or stop buffer mode
// - watermark flag is raised while sample count is at least watermark level
// - watermark level zero never raises the watermark flag
// - in triggered mode watermark level caps the kept pre-trigger samples
// - after trigger, ignore triggers, store 32 minus level, set overflow, hold
module sbf_buffer_ctl (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // buffer datapath events
    input  wire logic [1:0] buf_mode,
    input  wire logic       sample_push,
    input  wire logic       sample_pop,
    input  wire logic       trigger_in,
    // auto wake/sleep inputs
    input  wire logic       odr_tick,
    input  wire logic [7:0] auto_sleep_period,
    input  wire logic       other_wake_event,
    // status and control outputs
    output logic      [5:0] sample_count,
    output logic            watermark_flag,
    output logic            overflow_flag,
    output logic            flush_strobe,
    output logic            gate_status_clear,
    output logic            drop_oldest,
    output logic            collect_enable,
    output logic            sleep_mode
);

    sbf_pkg::sbf_ctl_state_t s_ff;
    sbf_pkg::sbf_ctl_state_t nxt_s;
    sbf_wake_if              wk ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic wm_hit(input logic [5:0] cnt, input logic [5:0] lvl);
        wm_hit = (lvl != 6'h00) && (cnt >= lvl);
    endfunction

    function automatic logic [5:0] post_len(input logic [5:0] lvl);
        post_len = `SBF_CAPACITY - lvl;
    endfunction

    logic             wr_hit;
    logic             mode_off;
    logic             mode_trig;
    logic             pop_ok;
    logic             host_flag_clear;
    logic [5:0]       cnt_tmp;

    assign wr_hit    = reg_wr && (reg_addr == `SBF_CTRL_ADDR);
    assign mode_off  = (buf_mode == sbf_pkg::SBF_MODE_OFF);
    assign mode_trig = (buf_mode == sbf_pkg::SBF_MODE_TRIG);
    assign pop_ok    = sample_pop && (s_ff.count != 6'h00);
    assign host_flag_clear = (s_ff.wm || s_ff.ovf)
                           && ((wr_hit && reg_wdata[`SBF_FLUSH_BIT]) || pop_ok);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        cnt_tmp = s_ff.count;
        nxt_s.flush = 1'b0;
        nxt_s.gclr = 1'b0;
        nxt_s.drop = 1'b0;
        if (wr_hit) begin
            nxt_s.wmrk = reg_wdata[`SBF_WMRK_MSB:0];
            nxt_s.src = reg_wdata[`SBF_SRC_BIT];
        end
        if (wr_hit && reg_wdata[`SBF_FLUSH_BIT]) begin
            // flush wins over any sample movement in the same cycle
            nxt_s.flush = 1'b1;
            nxt_s.gclr = 1'b1;
            cnt_tmp = `SBF_COUNT_RESET;
            nxt_s.ovf = 1'b0;
            nxt_s.post = 6'h00;
            nxt_s.tstate = sbf_pkg::SBF_TS_ARMED;
        end else if (mode_off) begin
            cnt_tmp = `SBF_COUNT_RESET;
            nxt_s.ovf = 1'b0;
            nxt_s.gclr = 1'b1;
            nxt_s.post = 6'h00;
            nxt_s.tstate = sbf_pkg::SBF_TS_ARMED;
        end else begin
            if (pop_ok) begin
                cnt_tmp = s_ff.count - 6'h01;
                nxt_s.ovf = 1'b0;
                if (s_ff.count == 6'h01) begin
                    nxt_s.gclr = 1'b1;
                end
            end
            if (mode_trig) begin
                case (s_ff.tstate)
                    sbf_pkg::SBF_TS_ARMED: begin
                        if (trigger_in) begin
                            nxt_s.tstate = sbf_pkg::SBF_TS_FILL;
                            nxt_s.post = 6'h00;
                        end else if (sample_push) begin
                            if (cnt_tmp < nxt_s.wmrk) begin
                                cnt_tmp = cnt_tmp + 6'h01;
                            end else begin
                                nxt_s.drop = 1'b1;
                            end
                        end
                    end
                    sbf_pkg::SBF_TS_FILL: begin
                        // further triggers fall through untouched here
                        if (sample_push && cnt_tmp < `SBF_CAPACITY) begin
                            cnt_tmp = cnt_tmp + 6'h01;
                            nxt_s.post = s_ff.post + 6'h01;
                            if (s_ff.post + 6'h01 >= post_len(s_ff.wmrk)
                                || cnt_tmp == `SBF_CAPACITY) begin
                                nxt_s.ovf = 1'b1;
                                nxt_s.tstate = sbf_pkg::SBF_TS_HELD;
                            end
                        end
                    end
                    sbf_pkg::SBF_TS_HELD: begin
                        nxt_s.ovf = 1'b1;
                        if (cnt_tmp == 6'h00) begin
                            nxt_s.ovf = 1'b0;
                            nxt_s.tstate = sbf_pkg::SBF_TS_ARMED;
                        end
                    end
                    default: begin
                        nxt_s.tstate = sbf_pkg::SBF_TS_ARMED;
                    end
                endcase
            end else begin
                nxt_s.tstate = sbf_pkg::SBF_TS_ARMED;
                if (sample_push) begin
                    if (cnt_tmp < `SBF_CAPACITY) begin
                        cnt_tmp = cnt_tmp + 6'h01;
                    end else begin
                        // stream drops the oldest, stop refuses the new one
                        nxt_s.ovf = 1'b1;
                        nxt_s.drop = (buf_mode == sbf_pkg::SBF_MODE_STREAM);
                    end
                end
            end
        end
        nxt_s.count = cnt_tmp;
        nxt_s.wm = wm_hit(cnt_tmp, nxt_s.wmrk);
        // flush bit is never stored, so it reads back as zero
        nxt_s.rdata = (reg_addr == `SBF_CTRL_ADDR) ? {1'b0, nxt_s.src, nxt_s.wmrk} : 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // auto wake/sleep link
    // ----------------------------------------------------------------
    assign wk.odr_tick    = odr_tick;
    assign wk.period      = auto_sleep_period;
    assign wk.wake_event  = other_wake_event || (mode_trig && trigger_in
                            && s_ff.tstate == sbf_pkg::SBF_TS_ARMED);
    assign wk.force_awake = mode_trig && (s_ff.tstate != sbf_pkg::SBF_TS_ARMED);
    assign wk.src_active  = s_ff.src && (buf_mode == sbf_pkg::SBF_MODE_STREAM
                            || buf_mode == sbf_pkg::SBF_MODE_STOP);
    assign wk.buf_flags   = s_ff.wm || s_ff.ovf;
    assign wk.flag_clear  = host_flag_clear;

    sbf_wake_timer u_wake (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wk      (wk)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata         = s_ff.rdata;
    assign sample_count      = s_ff.count;
    assign watermark_flag    = s_ff.wm;
    assign overflow_flag     = s_ff.ovf;
    assign flush_strobe      = s_ff.flush;
    assign gate_status_clear = s_ff.gclr;
    assign drop_oldest       = s_ff.drop;
    assign collect_enable    = !mode_off && !(mode_trig && s_ff.tstate == sbf_pkg::SBF_TS_HELD)
                               && !(buf_mode == sbf_pkg::SBF_MODE_STOP
                               && s_ff.count == `SBF_CAPACITY);
    assign sleep_mode        = wk.sleep;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_FLUSH_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn)
        flush_strobe |-> sample_count == 6'h00 && !overflow_flag && !watermark_flag)
        else $error("flush left samples or flags behind");
    AST_FLUSH_GATE: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_hit && reg_wdata[`SBF_FLUSH_BIT] |=> gate_status_clear && flush_strobe)
        else $error("flush did not clear gate status");
    AST_FLUSH_SELF_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
        flush_strobe && !(wr_hit && reg_wdata[`SBF_FLUSH_BIT]) |=> !flush_strobe)
        else $error("flush bit held past one cycle");
    AST_FLUSH_READS_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
        !reg_rdata[`SBF_FLUSH_BIT])
        else $error("flush bit seen high on readback");
    AST_SRC_MODE_GATE: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig || mode_off |-> !wk.src_active)
        else $error("keep-awake enable active outside stream or stop");
    AST_WM_COMPARE: assert property (@(posedge ref_clk) disable iff (!rstn)
        watermark_flag == (s_ff.wmrk != 6'h00 && sample_count >= s_ff.wmrk))
        else $error("watermark flag disagrees with count");
    AST_WM_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_ff.wmrk == 6'h00 |-> !watermark_flag)
        else $error("watermark raised at level zero");
    AST_PRETRIG_CAP: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig && s_ff.tstate == sbf_pkg::SBF_TS_ARMED && $stable(s_ff.wmrk)
        && $past(mode_trig) && $past(s_ff.count) <= s_ff.wmrk |-> sample_count <= s_ff.wmrk)
        else $error("pre-trigger samples exceed level");
    AST_HELD_OVF: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig && s_ff.tstate == sbf_pkg::SBF_TS_HELD |-> overflow_flag && !collect_enable)
        else $error("held trigger capture without overflow");
    AST_WM_EVERY_CYCLE: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_hit && !reg_wdata[`SBF_FLUSH_BIT] && !mode_off && !sample_push && !sample_pop
        |=> watermark_flag == ($past(reg_wdata[`SBF_WMRK_MSB:0]) != 6'h00
        && $past(sample_count) >= $past(reg_wdata[`SBF_WMRK_MSB:0])))
        else $error("watermark not refreshed after level write");
    AST_POP_CLEARS_OVF: assert property (@(posedge ref_clk) disable iff (!rstn)
        pop_ok && !mode_off && !mode_trig && !sample_push |=> !overflow_flag)
        else $error("sample read-out left overflow set");
    AST_FILL_IGNORES_TRIG: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig && s_ff.tstate == sbf_pkg::SBF_TS_FILL && trigger_in && !sample_push
        && !(wr_hit && reg_wdata[`SBF_FLUSH_BIT]) |=> s_ff.tstate == sbf_pkg::SBF_TS_FILL)
        else $error("trigger during capture disturbed the capture");

    COV_FLUSH: cover property (@(posedge ref_clk) disable iff (!rstn)
        overflow_flag ##1 flush_strobe);
    COV_WM_RISE: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(watermark_flag));
    COV_TRIG_HELD: cover property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig && $rose(s_ff.tstate == sbf_pkg::SBF_TS_HELD));
    COV_SLEEP: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(sleep_mode));
    COV_FILL_TRIG: cover property (@(posedge ref_clk) disable iff (!rstn)
        mode_trig && s_ff.tstate == sbf_pkg::SBF_TS_FILL && trigger_in);

endmodule // sbf_buffer_ctl

// File: sbf_cfg.svh
`ifndef SBF_CFG_SVH
`define SBF_CFG_SVH

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define SBF_CTRL_ADDR      8'h27
`define SBF_FLUSH_BIT      7
`define SBF_SRC_BIT        6
`define SBF_WMRK_MSB       5
`define SBF_CTRL_RESET     8'h00

// ----------------------------------------------------------------
// buffer sizing and counts
// ----------------------------------------------------------------
`define SBF_CAPACITY       6'h20
`define SBF_COUNT_RESET    6'h00
`define SBF_TIMER_RESET    8'h00

`endif

// File: sbf_host_model.sv
`timescale 1ns/1ps
module sbf_host_model (
    // clock
    input  wire logic       ref_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // sample read-out
    output logic            sample_pop
);
    initial begin
        reg_addr   = 8'h27;
        reg_wr     = 1'b0;
        reg_wdata  = 8'h00;
        sample_pop = 1'b0;
    end

    // --------------------------------------------------------
    // serial-side accesses, one register cycle each
    // --------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wr    = 1'b1;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_addr  = 8'h27;
        // released data bus must not keep showing the last value
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        d        = reg_rdata;
        reg_addr = 8'h27;
    endtask

    // one sample read out clears overflow outside a held trigger capture; watermark follows the count
    task automatic pop();
        @(negedge ref_clk);
        sample_pop = 1'b1;
        @(negedge ref_clk);
        sample_pop = 1'b0;
    endtask
endmodule // sbf_host_model

// File: sbf_pkg.sv
package sbf_pkg;

    // buffer mode field of buffer_control_register_one
    typedef enum logic [1:0] {
        SBF_MODE_OFF    = 2'b00,
        SBF_MODE_STREAM = 2'b01,
        SBF_MODE_STOP   = 2'b10,
        SBF_MODE_TRIG   = 2'b11
    } sbf_mode_t;

    typedef enum logic [1:0] {
        SBF_TS_ARMED = 2'b00,
        SBF_TS_FILL  = 2'b01,
        SBF_TS_HELD  = 2'b10
    } sbf_tstate_t;

    typedef struct packed {
        logic [5:0]  count;
        logic        ovf;
        logic        wm;
        logic [5:0]  wmrk;
        logic        src;
        sbf_tstate_t tstate;
        logic [5:0]  post;
        logic [7:0]  rdata;
        logic        flush;
        logic        gclr;
        logic        drop;
    } sbf_ctl_state_t;

    typedef struct packed {
        logic [7:0] tmr;
        logic       sleep;
        logic       flags_prev;
    } sbf_wake_state_t;

endpackage

// File: sbf_tb.sv
`timescale 1ns/1ps
module tb;
    logic       ref_clk, rstn, reg_wr, sample_push, sample_pop, trigger_in;
    logic       odr_tick, other_wake_event, watermark_flag, overflow_flag;
    logic       flush_strobe, gate_status_clear, drop_oldest, collect_enable, sleep_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, auto_sleep_period, rd_v, c;
    logic [1:0] buf_mode;
    logic [5:0] sample_count, lvl;
    int         miscompares, checks, seed;
    // {enable, mode, pop, expect sleep}
    logic [4:0] slp_case [5] = '{5'h07, 5'h16, 5'h1A, 5'h1F, 5'h15};
    // one-hot masks over {push, trigger, tick, wake}
    localparam logic [3:0] ev_push = 4'h8;
    localparam logic [3:0] ev_trig = 4'h4;
    localparam logic [3:0] ev_tick = 4'h2;
    localparam logic [3:0] ev_wake = 4'h1;

    sbf_buffer_ctl i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .buf_mode(buf_mode), .sample_push(sample_push), .sample_pop(sample_pop),
        .trigger_in(trigger_in), .odr_tick(odr_tick), .auto_sleep_period(auto_sleep_period),
        .other_wake_event(other_wake_event), .sample_count(sample_count),
        .watermark_flag(watermark_flag), .overflow_flag(overflow_flag),
        .flush_strobe(flush_strobe), .gate_status_clear(gate_status_clear),
        .drop_oldest(drop_oldest), .collect_enable(collect_enable), .sleep_mode(sleep_mode));
    sbf_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_pop(sample_pop));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    function automatic logic exp_wm(input logic [5:0] n, input logic [5:0] l);
        return (l != 6'h00) && (n >= l);
    endfunction
    task automatic pulse(input logic [3:0] m, input int n);
        @(negedge ref_clk);
        {sample_push, trigger_in, odr_tick, other_wake_event} = m;
        repeat (n) @(negedge ref_clk);
        {sample_push, trigger_in, odr_tick, other_wake_event} = 4'h0;
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // whole run is well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        seed = 71599;
        {rstn, sample_push, trigger_in, odr_tick, other_wake_event} = 5'h00;
        buf_mode = 2'b00;
        auto_sleep_period = 8'h00;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        i_host.rd(8'h27, rd_v);
        chk_byte(rd_v, 8'h00, "control reset value");
        chk_bit(sleep_mode | watermark_flag | overflow_flag, 1'b0, "flags after reset");
        // random control values, flush bit always set
        repeat (6) begin
            c = 8'($random(seed));
            i_host.wr(8'h27, c | 8'h80);
            i_host.rd(8'h27, rd_v);
            chk_byte(rd_v, {1'b0, c[6:0]}, "control readback");
        end
        i_host.wr(8'h28, 8'h3F);
        i_host.rd(8'h27, rd_v);
        chk_byte(rd_v, {1'b0, c[6:0]}, "unmapped write leaked");
        i_host.rd(8'h28, rd_v);
        chk_byte(rd_v, 8'h00, "unmapped read");
        // stream fill with watermark checked at every count
        buf_mode = 2'b01;
        lvl = 6'h01 + 6'($random(seed) & 32'h1F);
        i_host.wr(8'h27, {2'b10, lvl});
        for (int i = 1; i <= 32; i++) begin
            pulse(ev_push, 1);
            @(negedge ref_clk);
            chk_byte({2'b00, sample_count}, 8'(i), "stream count");
            chk_bit(watermark_flag, exp_wm(6'(i), lvl), "watermark");
        end
        i_host.wr(8'h27, 8'h21);
        @(negedge ref_clk);
        chk_bit(watermark_flag, 1'b0, "level above count");
        i_host.wr(8'h27, 8'h00);
        @(negedge ref_clk);
        chk_bit(watermark_flag, 1'b0, "level zero");
        pulse(ev_push, 1);
        chk_bit(overflow_flag & drop_oldest, 1'b1, "stream overflow");
        i_host.wr(8'h27, {2'b10, lvl});
        chk_bit(flush_strobe, 1'b1, "flush strobe");
        chk_bit(gate_status_clear, 1'b1, "gate status clear");
        chk_byte({overflow_flag, watermark_flag, sample_count}, 8'h00, "flush clear");
        // auto sleep against keep-awake enable and buffer mode
        auto_sleep_period = 8'h02;
        foreach (slp_case[k]) begin
            buf_mode = slp_case[k][3:2];
            i_host.wr(8'h27, {1'b1, slp_case[k][4], 6'h02});
            pulse(ev_push, 3);
            pulse(ev_wake, 1);
            pulse(ev_tick, 1);
            if (slp_case[k][1])
                i_host.pop();
            pulse(ev_tick, 1);
            repeat (2) @(negedge ref_clk);
            chk_bit(sleep_mode, slp_case[k][0], "sleep case");
        end
        auto_sleep_period = 8'h00;
        pulse(ev_wake, 1);
        // triggered mode: capped pre-trigger then post-trigger fill
        buf_mode = 2'b11;
        lvl = 6'h01 + 6'($random(seed) & 32'h0F);
        i_host.wr(8'h27, {2'b10, lvl});
        pulse(ev_push, 32'(lvl) + 3);
        chk_bit(drop_oldest, 1'b1, "pre-trigger drop");
        @(negedge ref_clk);
        chk_byte({2'b00, sample_count}, {2'b00, lvl}, "pre-trigger cap");
        pulse(ev_trig, 1);
        pulse(ev_push, 31 - 32'(lvl));
        @(negedge ref_clk);
        chk_bit(overflow_flag, 1'b0, "overflow early");
        pulse(ev_trig, 1);
        pulse(ev_push, 3);
        @(negedge ref_clk);
        chk_byte({overflow_flag, collect_enable, sample_count}, 8'hA0, "post fill");
        i_host.wr(8'h27, {2'b10, lvl});
        @(negedge ref_clk);
        chk_byte({overflow_flag, collect_enable, sample_count}, 8'h40, "rearm");
        give_verdict();
    end
endmodule // tb

// File: sbf_wake_if.sv
`timescale 1ns/1ps
interface sbf_wake_if;
    logic       odr_tick;
    logic [7:0] period;
    logic       wake_event;
    logic       force_awake;
    logic       src_active;
    logic       buf_flags;
    logic       flag_clear;
    logic       sleep;

    modport ctl (
        output odr_tick, period, wake_event, force_awake, src_active, buf_flags, flag_clear,
        input  sleep
    );
    modport tmr (
        input  odr_tick, period, wake_event, force_awake, src_active, buf_flags, flag_clear,
        output sleep
    );
endinterface

// File: sbf_wake_timer.sv
`timescale 1ns/1ps
`include "sbf_cfg.svh"
module sbf_wake_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // link to buffer control
    sbf_wake_if.tmr  wk
);

    sbf_pkg::sbf_wake_state_t s_ff;
    sbf_pkg::sbf_wake_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.flags_prev = wk.buf_flags;
        if (wk.wake_event || wk.force_awake) begin
            nxt_s.sleep = 1'b0;
            nxt_s.tmr = `SBF_TIMER_RESET;
        end else if (wk.src_active && wk.flag_clear) begin
            nxt_s.sleep = 1'b0;
            nxt_s.tmr = `SBF_TIMER_RESET;
        end else if (wk.src_active && wk.buf_flags && !s_ff.flags_prev) begin
            // a freshly raised flag restarts the wake period the host has to react in
            nxt_s.tmr = `SBF_TIMER_RESET;
        end else if (!s_ff.sleep && wk.odr_tick && wk.period != 8'h00) begin
            if (s_ff.tmr + 8'h01 >= wk.period) begin
                nxt_s.sleep = 1'b1;
                nxt_s.tmr = `SBF_TIMER_RESET;
            end else begin
                nxt_s.tmr = s_ff.tmr + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wk.sleep = s_ff.sleep;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_HOST_CLEAR_KEEPS_AWAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
        wk.src_active && wk.flag_clear |=> !s_ff.sleep && s_ff.tmr == 8'h00)
        else $error("host flag clear did not restart the auto-sleep timer");
    AST_EXPIRY_SLEEPS: assert property (@(posedge ref_clk) disable iff (!rstn)
        !s_ff.sleep && wk.odr_tick && wk.period != 8'h00 && s_ff.tmr + 8'h01 >= wk.period
        && !wk.wake_event && !wk.force_awake && !wk.flag_clear && !wk.buf_flags |=> s_ff.sleep)
        else $error("timer expiry did not enter sleep");
    AST_IGNORED_FLAGS: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wk.src_active && !wk.wake_event && !wk.force_awake && !wk.odr_tick
        |=> s_ff.tmr == $past(s_ff.tmr))
        else $error("buffer flags moved the timer while ignored");

endmodule // sbf_wake_timer
